// [rtl/axil_regs.sv]
// AXI4-Lite slave holding the call, stack pointer, status and config words.
// Assumes one outstanding write and one outstanding read from the master.
`timescale 1ns/100ps
module axil_regs
  import flash_seq_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic ce,
  input logic [AXI_AW-1:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [AXI_AW-1:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  seq_ctrl_if.regs ctl
);
  logic aw_q, w_q, bvalid_q, rvalid_q, start_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rd_word;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] func_q, sp_q;
  logic [2:0] cfg_q;
  logic do_write, wr_hit, rd_hit;

  assign awready = ce & ~aw_q & ~bvalid_q;
  assign wready = ce & ~w_q & ~bvalid_q;
  assign arready = ce & ~rvalid_q;
  assign do_write = aw_q & w_q & ~bvalid_q;
  assign wr_hit = (awaddr_q == REG_CTRL) || (awaddr_q == REG_SP) || (awaddr_q == REG_CFG);

  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case ({araddr[11:2], 2'b00})
      REG_CTRL: rd_word = {24'h00_0000, func_q};
      REG_SP: rd_word = {24'h00_0000, sp_q};
      REG_STATUS: rd_word = {8'h00, ctl.acc, ctl.result, 6'h00, ctl.halted, ctl.busy};
      REG_CFG: rd_word = {29'h0000_0000, cfg_q};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_q <= 1'b1;
        awaddr_q <= {awaddr[11:2], 2'b00};
      end
      if (wvalid && wready) begin
        w_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_write) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // A call written while the sequencer is busy or halted is dropped.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_q <= 8'h00;
      sp_q <= 8'h00;
      cfg_q <= CFG_RESET;
      start_q <= 1'b0;
    end else if (ce) begin
      start_q <= 1'b0;
      if (do_write && wstrb_q[0]) begin
        if (awaddr_q == REG_CTRL) begin
          func_q <= wdata_q[7:0];
          start_q <= ~ctl.busy;
        end
        if (awaddr_q == REG_SP) begin
          sp_q <= wdata_q[7:0];
        end
        if (awaddr_q == REG_CFG) begin
          cfg_q <= wdata_q[2:0];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign ctl.start = start_q;
  assign ctl.func = func_q;
  assign ctl.sp_val = sp_q;
  assign ctl.size_sel = cfg_q[1:0];
  assign ctl.ext_mode = cfg_q[CFG_EXT_BIT];
endmodule

// [rtl/flash_block_program_protect.sv]
// Supervisory flash sequencer: block program, block clear and protection raise.
// Assumes a synchronous-read SRAM (data one cycle after the sampled read),
// a flash macro driven by level strobes and a one-cycle flash read port.
//
// Functional notes
// - Block program copies exactly 64 consecutive SRAM bytes into one flash block.
// - Program of a write-locked block aborts: accumulator, second guard 00h, result 01h.
// - Clear of a write-locked block aborts the same way with result 01h.
// - Program source bytes start at the SRAM address held at FBh.
// - Program and clear pulse length is derived from the divider at FCh.
// - Valid block indices: 00h-7Fh for 8 KB, 00h-3Fh for 4 KB, 00h-2Fh for 3 KB.
// - Clear erases the 64 bytes of the indexed block, timed by the divider.
// - Clearing a block leaves its protection level untouched.
// - Protection code: 00b open, 01b read, 10b external write, 11b full.
// - Four codes per protection byte, lowest block in bits 1:0.
// - Protection byte k holds blocks 4k to 4k+3, last byte blocks 252-255.
// - Protection raise ORs 64 SRAM bytes from 80h into the protection block.
// - Protection only drops through the device wipe, which zeroes every byte; here a reset also clears every byte.
// - Table fetch reads of flash ignore protection codes.
// - Result codes: 00h done, 01h refused, 02h soft reset, 03h halted.
// - A wrong guard word halts the sequencer instead of running the call; here a soft reset call (00h) still runs unchecked.
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module flash_block_program_protect
  import flash_seq_pkg::*;
#(
  parameter int FLASH_AW = 13
) (
  input logic aclk,
  input logic aresetn,
  input logic ce,
  input logic [AXI_AW-1:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [AXI_AW-1:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  output logic [7:0] sram_addr,
  output logic sram_re,
  output logic sram_we,
  output logic [7:0] sram_wdata,
  input logic [7:0] sram_rdata,
  output logic [FLASH_AW-1:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_pgm,
  output logic flash_erase,
  output logic [FLASH_AW-1:0] flash_raddr,
  input logic [7:0] flash_rdata,
  input logic fetch_req,
  input logic [FLASH_AW-1:0] fetch_addr,
  output logic [7:0] fetch_data,
  output logic fetch_valid,
  input logic wipe_req,
  output logic cpu_stall
);
  seq_ctrl_if ctl ();

  seq_state_t state_q;
  seq_state_t check_next;
  logic [1:0] ph_q;
  logic [5:0] idx_q;
  logic [7:0] par_q [PARAM_COUNT];
  logic [7:0] prot_q [PROT_BYTES];
  logic [7:0] func_q;
  logic [7:0] res_q;
  logic [7:0] check_res;
  logic [7:0] acc_q;
  logic [7:0] byte_q;
  logic [7:0] block_idx;
  logic [7:0] block_limit;
  logic [1:0] prot_code;
  logic write_locked;
  logic keys_ok;
  logic is_protect;
  logic last_byte;
  logic ph_last;
  logic prot_wr;
  logic tmr_start_q;
  logic tmr_on;
  logic tmr_done;
  logic [7:0] sram_addr_q;
  logic sram_re_q;
  logic sram_we_q;
  logic [7:0] sram_wdata_q;
  logic [FLASH_AW-1:0] flash_addr_q;
  logic [7:0] flash_wdata_q;
  logic fetch_pend_q;
  logic fetch_valid_q;
  logic [7:0] fetch_data_q;

  axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .ctl(ctl.regs)
  );

  pulse_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .start(tmr_start_q),
    .div(par_q[PAR_DIV]),
    .delay(par_q[PAR_DELAY]),
    .on(tmr_on),
    .done(tmr_done)
  );

  assign block_idx = par_q[PAR_TARGET];
  // The block index picks a byte by its upper bits and a bit pair by its lower two.
  assign prot_code = prot_q[block_idx[7:2]][{block_idx[1:0], 1'b0} +: 2];
  // External programming is barred from 10b upward, internal calls only by 11b.
  assign write_locked = ctl.ext_mode ? prot_code[1] : (prot_code == PROT_FULL);
  assign keys_ok = (par_q[PAR_GUARD1] == GUARD1_VALUE) && (par_q[PAR_GUARD2] == ctl.sp_val);
  assign is_protect = (func_q == FN_PROTECT);
  assign last_byte = (idx_q == 6'(BLOCK_BYTES - 1));
  assign ph_last = (ph_q == 2'h2);
  assign prot_wr = (state_q == S_PROG) && is_protect && tmr_done;

  always_comb begin
    unique case (ctl.size_sel)
      SIZE_4K: block_limit = LIMIT_4K;
      SIZE_3K: block_limit = LIMIT_3K;
      default: block_limit = LIMIT_8K;
    endcase
  end

  // Decides the outcome of a call once all parameters have been read.
  always_comb begin
    check_next = S_RESULT;
    check_res = RC_OK;
    if (func_q == FN_SWRESET) begin
      check_res = RC_SWRST;
    end else if (!keys_ok) begin
      check_next = S_HALT;
    end else if (is_protect) begin
      check_next = S_FETCH;
    end else if (func_q != FN_PROGRAM && func_q != FN_CLEAR) begin
      check_next = S_HALT;
    end else if (block_idx > block_limit || write_locked) begin
      check_res = RC_PROT;
    end else if (func_q == FN_PROGRAM) begin
      check_next = S_FETCH;
    end else begin
      check_next = S_ERASE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
      ph_q <= 2'h0;
      idx_q <= 6'h00;
    end else if (ce) begin
      unique case (state_q)
        S_IDLE: begin
          if (ctl.start) begin
            state_q <= S_PARAM;
            ph_q <= 2'h0;
            idx_q <= 6'h00;
          end
        end
        S_PARAM: begin
          if (ph_last) begin
            ph_q <= 2'h0;
            if (idx_q == 6'(PARAM_COUNT - 1)) begin
              state_q <= S_CHECK;
              idx_q <= 6'h00;
            end else begin
              idx_q <= idx_q + 6'h01;
            end
          end else begin
            ph_q <= ph_q + 2'h1;
          end
        end
        S_CHECK: begin
          state_q <= check_next;
        end
        S_ERASE: begin
          if (tmr_done) begin
            state_q <= S_RESULT;
          end
        end
        S_FETCH: begin
          if (ph_last) begin
            ph_q <= 2'h0;
            state_q <= S_PROG;
          end else begin
            ph_q <= ph_q + 2'h1;
          end
        end
        S_PROG: begin
          if (tmr_done) begin
            if (last_byte) begin
              state_q <= S_RESULT;
              idx_q <= 6'h00;
            end else begin
              state_q <= S_FETCH;
              idx_q <= idx_q + 6'h01;
            end
          end
        end
        S_RESULT: begin
          if (ph_last) begin
            ph_q <= 2'h0;
            state_q <= S_IDLE;
          end else begin
            ph_q <= ph_q + 2'h1;
          end
        end
        S_HALT: begin
          state_q <= S_HALT;
        end
      endcase
    end
  end

  // Parameter capture, call code, staged data byte and result codes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < PARAM_COUNT; i++) begin
        par_q[i] <= 8'h00;
      end
      func_q <= 8'h00;
      res_q <= RC_OK;
      acc_q <= 8'h00;
      byte_q <= 8'h00;
    end else if (ce) begin
      if (state_q == S_IDLE && ctl.start) begin
        func_q <= ctl.func;
        acc_q <= ctl.func;
      end
      if (state_q == S_PARAM && ph_last) begin
        par_q[idx_q[2:0]] <= sram_rdata;
      end
      if (state_q == S_FETCH && ph_last) begin
        byte_q <= sram_rdata;
      end
      if (state_q == S_CHECK) begin
        res_q <= (check_next == S_HALT) ? RC_HALT : check_res;
      end
      if (state_q == S_RESULT && ph_last) begin
        acc_q <= 8'h00;
      end
    end
  end

  // SRAM accesses are registered; each read takes three phases, each result write one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sram_addr_q <= 8'h00;
      sram_re_q <= 1'b0;
      sram_we_q <= 1'b0;
      sram_wdata_q <= 8'h00;
    end else if (ce) begin
      sram_re_q <= 1'b0;
      sram_we_q <= 1'b0;
      if (ph_q == 2'h0 && state_q == S_PARAM) begin
        sram_re_q <= 1'b1;
        sram_addr_q <= ADDR_GUARD1 + {2'b00, idx_q};
      end
      if (ph_q == 2'h0 && state_q == S_FETCH) begin
        sram_re_q <= 1'b1;
        if (is_protect) begin
          sram_addr_q <= PROT_SRC + {2'b00, idx_q};
        end else begin
          sram_addr_q <= par_q[PAR_PTR] + {2'b00, idx_q};
        end
      end
      if (ph_q == 2'h0 && state_q == S_RESULT) begin
        sram_we_q <= 1'b1;
        sram_addr_q <= ADDR_GUARD1;
        sram_wdata_q <= res_q;
      end
      if (ph_q == 2'h1 && state_q == S_RESULT) begin
        sram_we_q <= 1'b1;
        sram_addr_q <= ADDR_GUARD2;
        sram_wdata_q <= 8'h00;
      end
    end
  end

  // Flash address, data and pulse start for each program byte or block clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_addr_q <= '0;
      flash_wdata_q <= 8'h00;
      tmr_start_q <= 1'b0;
    end else if (ce) begin
      tmr_start_q <= 1'b0;
      if (state_q == S_CHECK && check_next == S_ERASE) begin
        flash_addr_q <= FLASH_AW'({block_idx, 6'h00});
        tmr_start_q <= 1'b1;
      end
      if (state_q == S_FETCH && ph_last) begin
        flash_addr_q <= FLASH_AW'({block_idx, idx_q});
        flash_wdata_q <= sram_rdata;
        tmr_start_q <= 1'b1;
      end
    end
  end

  // Protection bytes only gain bits while running; the wipe or a reset clears them.
  for (genvar k = 0; k < PROT_BYTES; k++) begin : g_prot
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        prot_q[k] <= PROT_RESET;
      end else if (ce) begin
        if (wipe_req && state_q == S_IDLE) begin
          prot_q[k] <= 8'h00;
        end else if (prot_wr && idx_q == 6'(k)) begin
          prot_q[k] <= prot_q[k] | byte_q;
        end
      end
    end
  end

  // Table fetches read flash directly, with no protection lookup at all.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_pend_q <= 1'b0;
      fetch_valid_q <= 1'b0;
      fetch_data_q <= 8'h00;
    end else if (ce) begin
      fetch_pend_q <= fetch_req;
      fetch_valid_q <= fetch_pend_q;
      if (fetch_pend_q) begin
        fetch_data_q <= flash_rdata;
      end
    end
  end

  assign flash_raddr = fetch_addr;
  assign fetch_data = fetch_data_q;
  assign fetch_valid = fetch_valid_q;
  assign sram_addr = sram_addr_q;
  assign sram_re = sram_re_q;
  assign sram_we = sram_we_q;
  assign sram_wdata = sram_wdata_q;
  assign flash_addr = flash_addr_q;
  assign flash_wdata = flash_wdata_q;
  // The protection raise uses the pulse for timing only; user flash is not written.
  assign flash_pgm = tmr_on && (state_q == S_PROG) && !is_protect;
  assign flash_erase = tmr_on && (state_q == S_ERASE);
  assign ctl.busy = (state_q != S_IDLE);
  assign ctl.halted = (state_q == S_HALT);
  assign ctl.result = res_q;
  assign ctl.acc = acc_q;
  assign cpu_stall = (state_q != S_IDLE);
endmodule

// [rtl/pulse_timer.sv]
// Program and erase pulse timer: pulse from the divider, then a settle gap.
// Assumes start arrives only while the timer is idle.
`timescale 1ns/100ps
module pulse_timer
  import flash_seq_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic ce,
  input logic start,
  input logic [7:0] div,
  input logic [7:0] delay,
  output logic on,
  output logic done
);
  logic [15:0] cnt_q;
  logic on_q;
  logic gap_q;
  logic done_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 16'h0000;
      on_q <= 1'b0;
      gap_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      if (start) begin
        on_q <= 1'b1;
        gap_q <= 1'b0;
        cnt_q <= 16'((int'(div) + 1) * PULSE_UNIT_CYC - 1);
      end else if (on_q) begin
        if (cnt_q == 16'h0000) begin
          on_q <= 1'b0;
          gap_q <= 1'b1;
          cnt_q <= 16'(int'(delay) * DELAY_UNIT_CYC);
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
      end else if (gap_q) begin
        if (cnt_q == 16'h0000) begin
          gap_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
      end
    end
  end

  assign on = on_q;
  assign done = done_q;
endmodule

// [shared/flash_seq_pkg.sv]
// Constants, codes and state encoding shared by the flash sequencer files.
// Assumes one 100 MHz clock domain and a 12-bit AXI4-Lite byte address.
package flash_seq_pkg;
  localparam int CLK_MHZ = 100;
  localparam int BLOCK_BYTES = 64;
  localparam int PROT_BYTES = 64;
  localparam int PARAM_COUNT = 7;
  localparam int AXI_AW = 12;
  localparam int PULSE_UNIT_NS = 100;
  localparam int PULSE_UNIT_CYC = (PULSE_UNIT_NS * CLK_MHZ + 999) / 1000;
  localparam int DELAY_UNIT_NS = 10;
  localparam int DELAY_UNIT_CYC = (DELAY_UNIT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] ADDR_GUARD1 = 8'hF8;
  localparam logic [7:0] ADDR_GUARD2 = 8'hF9;
  localparam logic [7:0] PROT_SRC = 8'h80;
  localparam logic [7:0] GUARD1_VALUE = 8'h3A;
  localparam int PAR_GUARD1 = 0;
  localparam int PAR_GUARD2 = 1;
  localparam int PAR_TARGET = 2;
  localparam int PAR_PTR = 3;
  localparam int PAR_DIV = 4;
  localparam int PAR_DELAY = 6;
  localparam logic [7:0] FN_SWRESET = 8'h00;
  localparam logic [7:0] FN_PROGRAM = 8'h02;
  localparam logic [7:0] FN_CLEAR = 8'h03;
  localparam logic [7:0] FN_PROTECT = 8'h04;
  localparam logic [7:0] RC_OK = 8'h00;
  localparam logic [7:0] RC_PROT = 8'h01;
  localparam logic [7:0] RC_SWRST = 8'h02;
  localparam logic [7:0] RC_HALT = 8'h03;
  localparam logic [1:0] PROT_FULL = 2'h3;
  localparam logic [7:0] PROT_RESET = 8'h00;
  localparam logic [1:0] SIZE_8K = 2'h0;
  localparam logic [1:0] SIZE_4K = 2'h1;
  localparam logic [1:0] SIZE_3K = 2'h2;
  localparam logic [7:0] LIMIT_8K = 8'h7F;
  localparam logic [7:0] LIMIT_4K = 8'h3F;
  localparam logic [7:0] LIMIT_3K = 8'h2F;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_SP = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_CFG = 12'h00C;
  localparam int CFG_EXT_BIT = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_PARAM = 8'h02,
    S_CHECK = 8'h04,
    S_ERASE = 8'h08,
    S_FETCH = 8'h10,
    S_PROG = 8'h20,
    S_RESULT = 8'h40,
    S_HALT = 8'h80
  } seq_state_t;
endpackage

// [shared/seq_ctrl_if.sv]
// Control and status bundle between the register slave and the sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface seq_ctrl_if;
  logic start;
  logic [7:0] func;
  logic [7:0] sp_val;
  logic [1:0] size_sel;
  logic ext_mode;
  logic busy;
  logic halted;
  logic [7:0] result;
  logic [7:0] acc;
  modport regs (output start, func, sp_val, size_sel, ext_mode,
                input busy, halted, result, acc);
  modport seq (input start, func, sp_val, size_sel, ext_mode,
               output busy, halted, result, acc);
endinterface

// [verification/flash_seq_assertions.sv]
// Port checker for the flash sequencer top level.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/100ps
module flash_seq_assertions (
  input logic aclk,
  input logic aresetn,
  input logic ce,
  input logic arvalid,
  input logic arready,
  input logic rvalid,
  input logic sram_re,
  input logic sram_we,
  input logic flash_pgm,
  input logic flash_erase,
  input logic [7:0] flash_rdata,
  input logic fetch_req,
  input logic [7:0] fetch_data,
  input logic fetch_valid,
  input logic cpu_stall
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_answer;
    ##1 fetch_valid && fetch_data == $past(flash_rdata);
  endsequence
  sequence s_pgm_hold;
    flash_pgm [*8];
  endsequence
  property p_fetch; fetch_req && ce |=> s_answer; endproperty
  property p_pgm_len; $rose(flash_pgm) |-> s_pgm_hold; endproperty
  property p_erase_len; $rose(flash_erase) |-> flash_erase [*8]; endproperty
  property p_strobe_excl; !(flash_pgm && flash_erase); endproperty
  property p_strobe_stall; flash_pgm || flash_erase |-> cpu_stall; endproperty
  property p_sram_excl; !(sram_re && sram_we); endproperty
  property p_re_pulse; sram_re |=> !sram_re; endproperty
  property p_read; arvalid && arready |=> rvalid; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch answer wrong");
  a_pgm_len: assert property (p_pgm_len) else $error("program pulse short");
  a_erase_len: assert property (p_erase_len) else $error("erase pulse short");
  a_strobe_excl: assert property (p_strobe_excl) else $error("both strobes high");
  a_strobe_stall: assert property (p_strobe_stall) else $error("strobe without stall");
  a_sram_excl: assert property (p_sram_excl) else $error("sram read and write");
  a_re_pulse: assert property (p_re_pulse) else $error("sram read not a pulse");
  a_read: assert property (p_read) else $error("read answer late");
endmodule
bind flash_block_program_protect flash_seq_assertions u_chk (.*);

// [verification/mem_partner.sv]
// Behavioural SRAM and flash array facing the sequencer memory ports.
// Assumes the sequencer clock; the bench reaches the arrays hierarchically.
`timescale 1ns/100ps
module mem_partner (
  input logic aclk,
  input logic [7:0] sram_addr,
  input logic sram_re,
  input logic sram_we,
  input logic [7:0] sram_wdata,
  output logic [7:0] sram_rdata,
  input logic [12:0] flash_addr,
  input logic [7:0] flash_wdata,
  input logic flash_pgm,
  input logic flash_erase,
  input logic [12:0] flash_raddr,
  output logic [7:0] flash_rdata
);
  logic [7:0] sram [256];
  logic [7:0] flash [8192];
  logic pgm_q = 1'b0;
  logic erase_q = 1'b0;
  int pgm_count = 0;
  int erase_count = 0;
  logic [12:0] erase_addr = '0;
  initial begin
    foreach (flash[i]) flash[i] = 8'hFF;
    foreach (sram[i]) sram[i] = 8'h00;
    sram_rdata = 8'h00;
    flash_rdata = 8'h00;
  end
  always @(posedge aclk) begin
    // Stale read data toggles so a late capture cannot pass by luck.
    sram_rdata <= sram_re ? sram[sram_addr] : ~sram_rdata;
    if (sram_we) sram[sram_addr] <= sram_wdata;
    flash_rdata <= flash[flash_raddr];
    pgm_q <= flash_pgm;
    erase_q <= flash_erase;
    if (flash_pgm && !pgm_q) begin
      flash[flash_addr] <= flash_wdata;
      pgm_count++;
    end
    if (flash_erase && !erase_q) begin
      erase_count++;
      erase_addr <= flash_addr;
      for (int i = 0; i < 64; i++) flash[{flash_addr[12:6], 6'(i)}] <= 8'hFF;
    end
  end
endmodule

// [verification/tb.sv]
// Self-checking bench: calls over AXI4-Lite, memory model, table fetches.
// Assumes the checker is bound to the design from its own file.
`timescale 1ns/100ps
module tb;
  import flash_seq_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, fetch_req = 1'b0, wipe_req = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sram_re, sram_we, flash_pgm;
  logic flash_erase, fetch_valid, cpu_stall;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0;
  logic [1:0] bresp, rresp;
  logic [7:0] sram_addr, sram_wdata, sram_rdata, flash_wdata, flash_rdata, fetch_data;
  logic [12:0] flash_addr, flash_raddr, fetch_addr = '0;
  logic [7:0] seed = 8'h3B;
  int err_total = 0;
  int comparisons = 0;
  always #5 aclk = ~aclk;
  flash_block_program_protect dut (.*);
  mem_partner u_mem (.*);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic conclude();
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic axw(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic call(input logic [7:0] code, input logic [7:0] blk, input logic [7:0] g1,
                      input logic [7:0] rc);
    logic [1:0] r;
    logic [31:0] st;
    int n;
    n = 0;
    u_mem.sram[8'hF8] = g1;
    u_mem.sram[8'hF9] = 8'h5C;
    u_mem.sram[8'hFA] = blk;
    u_mem.sram[8'hFB] = 8'h10;
    u_mem.sram[8'hFC] = 8'h00;
    u_mem.sram[8'hFE] = 8'h01;
    axw(REG_SP, 8'h5C, 4'hF, r);
    axw(REG_CTRL, code, 4'hF, r);
    do begin
      @(posedge aclk);
      n++;
    end while (n < 40 || (cpu_stall && rc != RC_HALT));
    axr(REG_STATUS, st, r);
    chk("result", rc, st[15:8]);
    chk("halted", {7'h0, rc == RC_HALT}, {7'h0, st[1]});
    chk("stall", {7'h0, rc == RC_HALT}, {7'h0, cpu_stall});
    if (rc <= RC_PROT) begin
      chk("slot one", rc, u_mem.sram[8'hF8]);
      chk("slot two", 8'h00, u_mem.sram[8'hF9]);
      chk("accumulator", 8'h00, st[23:16]);
    end
  endtask
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    int p;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axr(12'h0F0, d, r);
    chk("unmapped read", {6'h0, RESP_SLVERR}, {6'h0, r});
    axw(12'h0F4, 8'h01, 4'hF, r);
    chk("unmapped write", {6'h0, RESP_SLVERR}, {6'h0, r});
    for (int i = 0; i < 64; i++) begin
      seed = lfsr(seed);
      u_mem.sram[8'h10 + 8'(i)] = seed;
    end
    p = u_mem.pgm_count;
    call(FN_PROGRAM, 8'h7F, GUARD1_VALUE, RC_OK);
    chk("pulses", 8'h40, 8'(u_mem.pgm_count - p));
    for (int i = 0; i < 64; i++) begin
      chk("flash", u_mem.sram[8'h10 + 8'(i)], u_mem.flash[{7'h7F, 6'(i)}]);
    end
    call(FN_CLEAR, 8'h7F, GUARD1_VALUE, RC_OK);
    chk("erase base", 8'h7F, {1'b0, u_mem.erase_addr[12:6]});
    chk("erase offset", 8'h00, {2'b0, u_mem.erase_addr[5:0]});
    u_mem.sram[8'h81] = 8'h0C;
    u_mem.sram[8'h9F] = 8'h80;
    call(FN_PROTECT, 8'h00, GUARD1_VALUE, RC_OK);
    p = u_mem.pgm_count + u_mem.erase_count;
    call(FN_PROGRAM, 8'h05, GUARD1_VALUE, RC_PROT);
    call(FN_CLEAR, 8'h05, GUARD1_VALUE, RC_PROT);
    chk("strobes", 8'(p), 8'(u_mem.pgm_count + u_mem.erase_count));
    call(FN_PROGRAM, 8'h04, GUARD1_VALUE, RC_OK);
    call(FN_CLEAR, 8'h7F, GUARD1_VALUE, RC_OK);
    for (int i = 0; i < 64; i++) u_mem.sram[8'h10 + 8'(i)] = 8'h00;
    call(FN_PROGRAM, 8'h7F, GUARD1_VALUE, RC_OK);
    chk("scrub", 8'h00, u_mem.flash[{7'h7F, 6'h2A}]);
    axw(REG_CFG, 8'h04, 4'hF, r);
    call(FN_PROGRAM, 8'h7F, GUARD1_VALUE, RC_PROT);
    u_mem.sram[8'h81] = 8'h00;
    call(FN_PROTECT, 8'h00, GUARD1_VALUE, RC_OK);
    call(FN_CLEAR, 8'h05, GUARD1_VALUE, RC_PROT);
    axw(REG_CFG, 8'h02, 4'hF, r);
    call(FN_CLEAR, 8'h30, GUARD1_VALUE, RC_PROT);
    call(FN_CLEAR, 8'h2F, GUARD1_VALUE, RC_OK);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      fetch_addr <= {6'h02, seed[6:0]};
      fetch_req <= 1'b1;
      @(posedge aclk);
      fetch_req <= 1'b0;
      @(posedge aclk);
      #1;
      chk("fetch", u_mem.flash[{6'h02, seed[6:0]}], fetch_data);
      @(posedge aclk);
    end
    axw(REG_CFG, 8'h00, 4'hF, r);
    wipe_req <= 1'b1;
    @(posedge aclk);
    wipe_req <= 1'b0;
    call(FN_PROGRAM, 8'h05, GUARD1_VALUE, RC_OK);
    call(FN_SWRESET, 8'h00, 8'h00, RC_SWRST);
    call(FN_PROGRAM, 8'h05, 8'h3B, RC_HALT);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    call(8'h09, 8'h00, GUARD1_VALUE, RC_HALT);
    conclude();
  end
  initial begin
    repeat (40000) @(posedge aclk);
    err_total++;
    conclude();
  end
endmodule
